// >>> logic/sim_mem_device.sv
// Simulation memory board: block mapper, attribute mappers, lanes, parity.
`timescale 1ns/1ps
`default_nettype none
`include "sim_mem_consts.svh"

module sim_mem_device #(
    parameter int BANK_AW = 14
) (
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    mem_bus_if.device                 bus,
    input  wire logic                 addr_20bit,
    output logic [7:0]                col_strobe_n,
    output logic [BANK_AW/2-1:0]      mux_addr,
    output logic                      parity_irq
);
    import sim_mem_pkg::*;

    localparam int ROW_W = BANK_AW / 2;
    localparam int MEM_DEPTH = 4 << BANK_AW;

    dev_state_t                 state_q;
    logic [7:0]                 mapper   [0:`MAP_DEPTH-1];
    logic [1:0]                 attr     [0:`ATTR_DEPTH-1];
    logic [8:0]                 mem_even [0:MEM_DEPTH-1];
    logic [8:0]                 mem_odd  [0:MEM_DEPTH-1];
    logic [`MAP_AW-1:0]         map_idx;
    logic [7:0]                 map_word;
    logic                       mapped;
    logic [1:0]                 bank_sel;
    logic [`ATTR_AW-1:0]        attr_idx;
    logic [BANK_AW+1:0]         mem_idx;
    logic                       even_en;
    logic                       odd_en;
    logic                       odd_high;
    logic                       cycle_on;
    logic                       sys_cyc;
    logic [8:0]                 rd_even;
    logic [8:0]                 rd_odd;
    logic [15:0]                data_q;
    logic                       data_oe_q;
    logic                       ready_q;
    logic                       perr_q;
    logic                       wprot_n_q;
    logic                       loc_n_q;
    logic [7:0]                 strobe_n_q;
    logic [ROW_W-1:0]           mux_q;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------

    // The jumper narrows the decode; upper mapper index bits are forced low.
    always_comb begin
        if (addr_20bit) begin
            map_idx = {{`BLK_PAD_20{1'b0}}, bus.bus_addr[`BLK_HI_20:`BLK_LO]};
        end else begin
            map_idx = bus.bus_addr[`BLK_HI_26:`BLK_LO];
        end
    end

    assign map_word = mapper[map_idx];
    assign mapped   = (map_word != `MAP_UNMAPPED);

    // Lowest bank pair holding a zero wins; two banks mapped to the same
    // 4K block is a software error; only the lower one is read or written, though both pairs get strobes.
    always_comb begin
        bank_sel = 2'h0;
        for (int k = 3; k >= 0; k--) begin
            if (map_word[2*k] == 1'b0 || map_word[2*k+1] == 1'b0) begin
                bank_sel = k[1:0];
            end
        end
    end

    assign attr_idx = {bank_sel, bus.bus_addr[`ATTR_HI:`ATTR_LO]};
    assign mem_idx  = {bank_sel, bus.bus_addr[BANK_AW:1]};

    // Byte lane decode from byte mode, upper lane enable and address bit 0.
    always_comb begin
        even_en  = 1'b0;
        odd_en   = 1'b0;
        odd_high = 1'b0;
        if (bus.byte_mode) begin
            even_en = ~bus.bus_addr[0];
            odd_en  = bus.bus_addr[0];
        end else begin
            even_en  = ~bus.bus_addr[0];
            odd_en   = bus.upper_lane_enable & bus.bus_addr[0];
            odd_high = bus.upper_lane_enable;
            if (bus.upper_lane_enable && !bus.bus_addr[0]) begin
                odd_en = 1'b1;
            end
        end
    end

    assign cycle_on = ~bus.mem_cycle_n;
    assign sys_cyc  = bus.sys_sel;
    assign rd_even  = mem_even[mem_idx];
    assign rd_odd   = mem_odd[mem_idx];

    // ------------------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------------------

    // Row, then column, then answer; a strobe released early aborts the cycle.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= D_IDLE;
        end else if (!cycle_on) begin
            state_q <= D_IDLE;
        end else begin
            unique case (state_q)
                D_IDLE: state_q <= D_ROW;
                D_ROW:  state_q <= D_COL;
                D_COL:  state_q <= D_DONE;
                D_DONE: state_q <= D_DONE;
            endcase
        end
    end

    // Row address first, column address next, from bits 1..14.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mux_q <= '0;
        end else if (state_q == D_IDLE && cycle_on) begin
            mux_q <= bus.bus_addr[ROW_W:1];
        end else if (state_q == D_ROW) begin
            mux_q <= bus.bus_addr[BANK_AW:ROW_W+1];
        end
    end

    // Strobes are the mapper pattern gated by the active lanes.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            strobe_n_q <= `MAP_UNMAPPED;
        end else if (!cycle_on || sys_cyc) begin
            strobe_n_q <= `MAP_UNMAPPED;
        end else if (state_q == D_ROW) begin
            for (int k = 0; k < 4; k++) begin
                strobe_n_q[2*k]   <= map_word[2*k] | ~even_en;
                strobe_n_q[2*k+1] <= map_word[2*k+1] | ~odd_en;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Mapper and array storage
    // ------------------------------------------------------------------------

    // Mappers come up unmapped so a stray cycle after reset touches nothing.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `MAP_DEPTH; i++) begin
                mapper[i] <= `MAP_UNMAPPED;
            end
        end else if (state_q == D_COL && cycle_on && sys_cyc && !bus.write_n
                     && bus.sys_addr == `SYS_BLOCK_MAP) begin
            mapper[map_idx] <= bus.host_data[7:0];
        end
    end

    // Attribute writes need bits 4 and 5 low and a mapped address.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `ATTR_DEPTH; i++) begin
                attr[i] <= `ATTR_RESET;
            end
        end else if (state_q == D_COL && cycle_on && sys_cyc && !bus.write_n
                     && bus.sys_addr == `SYS_ATTR_MAP && mapped
                     && !bus.host_data[`ATTR_GUARD_LO]
                     && !bus.host_data[`ATTR_GUARD_HI]) begin
            attr[attr_idx] <= {bus.host_data[`ATTR_LOC_BIT],
                               bus.host_data[`ATTR_PROT_BIT]};
        end
    end

    // Array content is not reset, as in the real RAM; parity is odd over nine.
    always_ff @(posedge clk_sys) begin
        if (state_q == D_COL && cycle_on && !sys_cyc && !bus.write_n && mapped) begin
            if (even_en && !map_word[2*bank_sel]) begin
                mem_even[mem_idx] <= {~(^bus.host_data[7:0]), bus.host_data[7:0]};
            end
            if (odd_en && !map_word[2*bank_sel+1]) begin
                if (odd_high) begin
                    mem_odd[mem_idx] <= {~(^bus.host_data[15:8]),
                                         bus.host_data[15:8]};
                end else begin
                    mem_odd[mem_idx] <= {~(^bus.host_data[7:0]),
                                         bus.host_data[7:0]};
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------------------

    // Read data, attributes and parity are captured as the cycle completes.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_q    <= '0;
            data_oe_q <= 1'b0;
            ready_q   <= 1'b0;
            perr_q    <= 1'b0;
            wprot_n_q <= 1'b1;
            loc_n_q   <= 1'b1;
        end else if (!cycle_on) begin
            data_oe_q <= 1'b0;
            ready_q   <= 1'b0;
            perr_q    <= 1'b0;
            wprot_n_q <= 1'b1;
            loc_n_q   <= 1'b1;
        end else if (state_q == D_COL) begin
            ready_q   <= 1'b1;
            data_q    <= '0;
            data_oe_q <= 1'b0;
            perr_q    <= 1'b0;
            wprot_n_q <= ~(mapped & ~sys_cyc & attr[attr_idx][`ATTR_PROT_BIT]);
            loc_n_q   <= ~(mapped & ~sys_cyc & attr[attr_idx][`ATTR_LOC_BIT]);
            if (sys_cyc && bus.write_n && bus.sys_addr == `SYS_BLOCK_MAP) begin
                data_q    <= {8'h00, map_word};
                data_oe_q <= 1'b1;
            end else if (!sys_cyc && bus.write_n && mapped) begin
                data_oe_q <= even_en | odd_en;
                if (even_en) begin
                    data_q[7:0] <= rd_even[7:0];
                end
                if (odd_en && odd_high) begin
                    data_q[15:8] <= rd_odd[7:0];
                end else if (odd_en) begin
                    data_q[7:0] <= rd_odd[7:0];
                end
                perr_q <= (even_en & ~(^rd_even)) | (odd_en & ~(^rd_odd));
            end
        end
    end

    // One-cycle interrupt pulse on the first cycle a parity failure shows.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            parity_irq <= 1'b0;
        end else begin
            parity_irq <= cycle_on && state_q == D_COL && !sys_cyc && bus.write_n
                          && mapped && ((even_en & ~(^rd_even)) | (odd_en & ~(^rd_odd)));
        end
    end

    assign bus.dev_data        = data_q;
    assign bus.dev_data_oe     = data_oe_q;
    assign bus.mem_ready       = ready_q;
    assign bus.parity_err      = perr_q;
    assign bus.write_protect_n = wprot_n_q;
    assign bus.locality_n      = loc_n_q;
    assign col_strobe_n        = strobe_n_q;
    assign mux_addr            = mux_q;

endmodule // sim_mem_device

`default_nettype wire

// >>> logic/sim_mem_consts.svh
// Named constants shared by both ends of the simulation memory bus.
`ifndef SIM_MEM_CONSTS_SVH
`define SIM_MEM_CONSTS_SVH

// ----------------------------------------------------------------------------
// System device addresses
// ----------------------------------------------------------------------------
`define SYS_BLOCK_MAP     4'h3
`define SYS_ATTR_MAP      4'hF

// ----------------------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------------------
`define ADDR_W            26
`define DATA_W            16
`define BLK_LO            12
`define BLK_HI_26         25
`define BLK_HI_20         19
`define BLK_PAD_20        6
`define ATTR_LO           8
`define ATTR_HI           12
`define ATTR_AW           7
`define MAP_AW            14
`define MAP_DEPTH         16384
`define ATTR_DEPTH        128

// ----------------------------------------------------------------------------
// Mapper contents and attribute data bits
// ----------------------------------------------------------------------------
`define MAP_UNMAPPED      8'hFF
`define ATTR_RESET        2'h0
`define ATTR_PROT_BIT     0
`define ATTR_LOC_BIT      1
`define ATTR_GUARD_LO     4
`define ATTR_GUARD_HI     5

`endif

// >>> logic/sim_mem_pkg.sv
// Types shared by both ends of the simulation memory bus.
package sim_mem_pkg;

    // ------------------------------------------------------------------------
    // Device end memory cycle sequencer
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        D_IDLE = 4'b0001,
        D_ROW  = 4'b0010,
        D_COL  = 4'b0100,
        D_DONE = 4'b1000
    } dev_state_t;

    // ------------------------------------------------------------------------
    // Host end bus cycle sequencer
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        H_IDLE    = 4'b0001,
        H_SETUP   = 4'b0010,
        H_STROBE  = 4'b0100,
        H_RELEASE = 4'b1000
    } host_state_t;

endpackage

// >>> logic/mem_bus_if.sv
// Emulator bus signals between the host processor and the simulation memory.
`timescale 1ns/1ps
`default_nettype none

interface mem_bus_if;
    logic [25:0] bus_addr;
    logic [15:0] host_data;
    logic [15:0] dev_data;
    logic        dev_data_oe;
    logic        upper_lane_enable;
    logic        byte_mode;
    logic        write_n;
    logic        sys_sel;
    logic [3:0]  sys_addr;
    logic        mem_cycle_n;
    logic        mem_ready;
    logic        parity_err;
    logic        write_protect_n;
    logic        locality_n;

    modport device (
        input  bus_addr, host_data, upper_lane_enable, byte_mode, write_n,
               sys_sel, sys_addr, mem_cycle_n,
        output dev_data, dev_data_oe, mem_ready, parity_err, write_protect_n,
               locality_n
    );

    modport host (
        output bus_addr, host_data, upper_lane_enable, byte_mode, write_n,
               sys_sel, sys_addr, mem_cycle_n,
        input  dev_data, dev_data_oe, mem_ready, parity_err, write_protect_n,
               locality_n
    );
endinterface

`default_nettype wire

// >>> logic/sim_mem_host.sv
// Host end: runs one emulator bus memory or system device cycle per request.
`timescale 1ns/1ps
`default_nettype none
`include "sim_mem_consts.svh"

module sim_mem_host (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    mem_bus_if.host          bus,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic        req_sys,
    input  wire logic [3:0]  req_sys_addr,
    input  wire logic [25:0] req_addr,
    input  wire logic [15:0] req_data,
    input  wire logic        req_upper,
    input  wire logic        req_byte,
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    output logic             rsp_data_valid,
    output logic             rsp_parity_err,
    output logic             rsp_protect,
    output logic             rsp_local
);
    import sim_mem_pkg::*;

    host_state_t  state_q;
    logic [25:0]  addr_q;
    logic [15:0]  data_q;
    logic         upper_q;
    logic         byte_q;
    logic         write_n_q;
    logic         sys_q;
    logic [3:0]   sys_addr_q;
    logic         strobe_n_q;

    // ------------------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------------------

    assign req_ready = (state_q == H_IDLE);

    // Address and data are held stable for the whole cycle.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            addr_q     <= '0;
            data_q     <= '0;
            upper_q    <= 1'b0;
            byte_q     <= 1'b0;
            write_n_q  <= 1'b1;
            sys_q      <= 1'b0;
            sys_addr_q <= 4'h0;
        end else if (req_valid && req_ready) begin
            addr_q     <= req_addr;
            data_q     <= req_data;
            upper_q    <= req_upper;
            byte_q     <= req_byte;
            write_n_q  <= ~req_write;
            sys_q      <= req_sys;
            sys_addr_q <= req_sys_addr;
            if (req_sys && req_sys_addr == `SYS_ATTR_MAP) begin
                data_q[`ATTR_GUARD_LO] <= 1'b0;
                data_q[`ATTR_GUARD_HI] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------------------

    // One setup cycle before the strobe falls; the strobe is held until ready,
    // then the host waits for ready to drop so cycles never overlap.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= H_IDLE;
            strobe_n_q <= 1'b1;
        end else begin
            unique case (state_q)
                H_IDLE: begin
                    if (req_valid) begin
                        state_q <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    strobe_n_q <= 1'b0;
                    state_q    <= H_STROBE;
                end
                H_STROBE: begin
                    if (bus.mem_ready) begin
                        strobe_n_q <= 1'b1;
                        state_q    <= H_RELEASE;
                    end
                end
                H_RELEASE: begin
                    if (!bus.mem_ready) begin
                        state_q <= H_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Response capture
    // ------------------------------------------------------------------------

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid      <= 1'b0;
            rsp_data       <= '0;
            rsp_data_valid <= 1'b0;
            rsp_parity_err <= 1'b0;
            rsp_protect    <= 1'b0;
            rsp_local      <= 1'b0;
        end else begin
            rsp_valid <= (state_q == H_STROBE) && bus.mem_ready;
            if (state_q == H_STROBE && bus.mem_ready) begin
                rsp_data       <= bus.dev_data;
                rsp_data_valid <= bus.dev_data_oe;
                rsp_parity_err <= bus.parity_err;
                rsp_protect    <= ~bus.write_protect_n;
                rsp_local      <= ~bus.locality_n;
            end
        end
    end

    assign bus.bus_addr          = addr_q;
    assign bus.host_data         = data_q;
    assign bus.upper_lane_enable = upper_q;
    assign bus.byte_mode         = byte_q;
    assign bus.write_n           = write_n_q;
    assign bus.sys_sel           = sys_q;
    assign bus.sys_addr          = sys_addr_q;
    assign bus.mem_cycle_n       = strobe_n_q;

endmodule // sim_mem_host

`default_nettype wire

// >>> tb/sim_mem_chk.sv
// Concurrent checks on the memory bus that joins the host and device ends.
`timescale 1ns/1ps
`default_nettype none
`include "sim_mem_consts.svh"

module sim_mem_chk (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [25:0] bus_addr,
    input wire logic        upper_lane_enable,
    input wire logic        byte_mode,
    input wire logic        write_n,
    input wire logic        sys_sel,
    input wire logic [3:0]  sys_addr,
    input wire logic        mem_cycle_n,
    input wire logic        mem_ready,
    input wire logic        dev_data_oe,
    input wire logic        parity_err,
    input wire logic        write_protect_n,
    input wire logic        locality_n
);
    // ------------------------------------------------------------------------
    // Bus timing and answer checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // The device answers a fixed three edges after it first sees the strobe low.
    ready_latency_a: assert property (
        $fell(mem_cycle_n) |-> !mem_ready [*3] ##1 mem_ready) else $error("ready latency wrong");
    ready_drop_a: assert property (
        mem_cycle_n |=> !mem_ready) else $error("ready outlived the strobe");
    ready_hold_a: assert property (
        mem_ready && !mem_cycle_n |=> mem_ready) else $error("ready dropped early");
    // Data is driven only on answered reads, never on writes.
    drive_read_a: assert property (
        dev_data_oe |-> mem_ready && write_n) else $error("data driven outside a read");
    parity_read_a: assert property (
        parity_err |-> mem_ready && write_n && !sys_sel) else $error("parity flag off a read");
    sys_attr_idle_a: assert property (
        mem_ready && sys_sel |-> write_protect_n && locality_n) else $error("attrs on sys cycle");
    map_read_a: assert property (
        mem_ready && sys_sel && write_n && sys_addr == `SYS_BLOCK_MAP |-> dev_data_oe)
        else $error("mapper read gave no data");
    attr_read_a: assert property (
        mem_ready && sys_sel && write_n && sys_addr == `SYS_ATTR_MAP |-> !dev_data_oe)
        else $error("attribute read drove data");
    noop_lane_a: assert property (
        mem_ready && !sys_sel && !byte_mode && !upper_lane_enable && bus_addr[0] |-> !dev_data_oe)
        else $error("no-op lane drove data");
    attr_level_a: assert property (
        !write_protect_n || !locality_n |-> mem_ready) else $error("attr without ready");

    // Main traffic kinds that the bench must reach.
    cover property (mem_ready && dev_data_oe && !sys_sel);
    cover property (mem_ready && sys_sel && !write_n);
    cover property (mem_ready && !write_protect_n);
endmodule // sim_mem_chk
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench: host and device ends joined across the memory bus.
`timescale 1ns/1ps
`default_nettype none
`include "sim_mem_consts.svh"

module tb_top;
    logic        clk_sys = 1'h0, reset_n = 1'h0, addr_20bit = 1'h0, req_valid = 1'h0;
    logic        req_write = 1'h0, req_sys = 1'h0, req_upper = 1'h0, req_byte = 1'h0;
    logic [3:0]  req_sys_addr = 4'h0;
    logic [25:0] req_addr = 26'h0000000;
    logic [15:0] req_data = 16'h0000;
    logic        req_ready, rsp_valid, rsp_data_valid, rsp_parity_err, rsp_protect, rsp_local;
    logic [15:0] rsp_data;
    int          mismatches = 0, n_checks = 0;
    logic [7:0]  col_strobe_n;
    logic [6:0]  mux_addr;
    logic        parity_irq, irq_seen = 1'h0;

    // ------------------------------------------------------------------------
    // Both ends and the checker
    // ------------------------------------------------------------------------
    mem_bus_if bus_if ();
    sim_mem_device #(.BANK_AW(14)) i_sim_mem_device (.clk_sys, .reset_n, .bus(bus_if),
        .addr_20bit, .col_strobe_n, .mux_addr, .parity_irq);
    sim_mem_host i_sim_mem_host (.clk_sys, .reset_n, .bus(bus_if), .req_valid, .req_ready,
        .req_write, .req_sys, .req_sys_addr, .req_addr, .req_data, .req_upper, .req_byte,
        .rsp_valid, .rsp_data, .rsp_data_valid, .rsp_parity_err, .rsp_protect, .rsp_local);
    sim_mem_chk i_sim_mem_chk (.clk_sys, .reset_n, .bus_addr(bus_if.bus_addr),
        .upper_lane_enable(bus_if.upper_lane_enable), .byte_mode(bus_if.byte_mode),
        .write_n(bus_if.write_n), .sys_sel(bus_if.sys_sel), .sys_addr(bus_if.sys_addr),
        .mem_cycle_n(bus_if.mem_cycle_n), .mem_ready(bus_if.mem_ready),
        .dev_data_oe(bus_if.dev_data_oe), .parity_err(bus_if.parity_err),
        .write_protect_n(bus_if.write_protect_n), .locality_n(bus_if.locality_n));

    // 40 MHz system clock.
    always #12.5 clk_sys = ~clk_sys;

    // Every stored byte carries good parity, so any interrupt pulse is a fault.
    always @(posedge clk_sys) begin
        if (reset_n && parity_irq !== 1'h0) begin
            irq_seen <= 1'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] want);
        n_checks++;
        if (got !== want) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, want, got);
        end
    endtask

    // One request; the response lands a fixed five edges after the take.
    task automatic op(input logic wr, sys, input logic [3:0] sa, input logic [25:0] a,
                      input logic [15:0] d, input logic up, by);
        while (req_ready !== 1'h1) @(posedge clk_sys) #2;
        {req_write, req_sys, req_sys_addr, req_addr, req_data} = {wr, sys, sa, a, d};
        {req_upper, req_byte} = {up, by};
        req_valid = 1'h1;
        @(posedge clk_sys) #2;
        req_valid = 1'h0;
        repeat (5) @(posedge clk_sys);
        #2 check("rsp_valid", {15'h0000, rsp_valid}, 16'h0001);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    // Map one block on bank 0, write a word, then read it back through every lane mode.
    task automatic t_lanes();
        logic [2:0]  cfg [5] = '{3'h2, 3'h0, 3'h3, 3'h5, 3'h6}; // Byte, upper lane, a0.
        logic [15:0] msk [5] = '{16'hFFFF, 16'h00FF, 16'hFF00, 16'h00FF, 16'h00FF};
        logic [15:0] want [5] = '{16'hA5C3, 16'h00C3, 16'hA500, 16'h00A5, 16'h00C3};
        logic [7:0]  stb [5] = '{8'hFC, 8'hFE, 8'hFD, 8'hFD, 8'hFE};
        op(1'h1, 1'h1, `SYS_BLOCK_MAP, 26'h0005000, 16'h00FC, 1'h0, 1'h0);
        op(1'h0, 1'h1, `SYS_BLOCK_MAP, 26'h0005000, 16'h0000, 1'h0, 1'h0);
        check("map_rd", {8'h00, rsp_data[7:0]}, 16'h00FC);
        op(1'h1, 1'h0, 4'h0, 26'h0005000, 16'hA5C3, 1'h1, 1'h0);
        for (int i = 0; i < 5; i++) begin
            op(1'h0, 1'h0, 4'h0, {25'h0002800, cfg[i][0]}, 16'h0000, cfg[i][1], cfg[i][2]);
            check("lane_data", rsp_data & msk[i], want[i]);
            check("lane_par", {rsp_data_valid, rsp_parity_err}, 16'h0002);
            check("lane_stb", {8'h00, col_strobe_n}, {8'h00, stb[i]});
            check("col_addr", {9'h000, mux_addr}, 16'h0050);
        end
        op(1'h0, 1'h0, 4'h0, 26'h0005001, 16'h0000, 1'h0, 1'h0);
        check("noop", {15'h0000, rsp_data_valid}, 16'h0000);
    endtask

    // Upper address bits decode in full mode and are ignored under the 20-bit jumper.
    task automatic t_decode();
        op(1'h0, 1'h0, 4'h0, 26'h2005000, 16'h0000, 1'h1, 1'h0);
        check("hi_unmap", {rsp_data_valid, rsp_parity_err}, 16'h0000);
        check("hi_stb", {8'h00, col_strobe_n}, 16'h00FF);
        op(1'h1, 1'h1, `SYS_BLOCK_MAP, 26'h3FFF000, 16'h00F3, 1'h0, 1'h0);
        op(1'h1, 1'h0, 4'h0, 26'h3FFF000, 16'h1234, 1'h1, 1'h0);
        op(1'h0, 1'h0, 4'h0, 26'h3FFF000, 16'h0000, 1'h1, 1'h0);
        check("bank1_data", rsp_data, 16'h1234);
        check("bank1_stb", {8'h00, col_strobe_n}, 16'h00F3);
        op(1'h0, 1'h0, 4'h0, 26'h0006000, 16'h0000, 1'h1, 1'h0);
        check("ff_unmap", {15'h0000, rsp_data_valid}, 16'h0000);
        addr_20bit = 1'h1;
        op(1'h0, 1'h0, 4'h0, 26'h2005000, 16'h0000, 1'h1, 1'h0);
        check("short_map", rsp_data, 16'hA5C3);
        addr_20bit = 1'h0;
    endtask

    // Attributes land on one 256-byte page only and read back as no data.
    task automatic t_attr();
        op(1'h1, 1'h1, `SYS_ATTR_MAP, 26'h0005000, 16'h0003, 1'h0, 1'h0);
        op(1'h0, 1'h0, 4'h0, 26'h0005000, 16'h0000, 1'h1, 1'h0);
        check("attr_set", {rsp_protect, rsp_local}, 16'h0003);
        op(1'h0, 1'h0, 4'h0, 26'h0005101, 16'h0000, 1'h0, 1'h0);
        check("attr_next", {rsp_protect, rsp_local}, 16'h0000);
        op(1'h0, 1'h1, `SYS_ATTR_MAP, 26'h0005000, 16'h0000, 1'h0, 1'h0);
        check("attr_rd", {15'h0000, rsp_data_valid}, 16'h0000);
        check("irq_none", {15'h0000, irq_seen}, 16'h0000);
    endtask

    // Main sequence after five cycles of reset.
    initial begin
        repeat (5) @(posedge clk_sys);
        #2 reset_n = 1'h1;
        t_lanes();
        t_decode();
        t_attr();
        close_out();
    end

    // Watchdog: the run needs about 150 cycles, so 4000 means a hang.
    initial begin
        repeat (4000) @(posedge clk_sys);
        mismatches++;
        close_out();
    end
endmodule // tb_top
`default_nettype wire
